// ### rtl/dclm_pkg.sv
// constants and carrier types for the dual channel limit monitor
package dclm_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0]  IDX_CONFIG2  = 4'h2;
  localparam logic [3:0]  IDX_STATUS   = 4'h3;
  localparam logic [3:0]  IDX_LOWER    = 4'h4;
  localparam logic [3:0]  IDX_UPPER    = 4'h5;
  localparam logic [3:0]  IDX_IRQ_EN   = 4'h6;
  localparam logic [3:0]  IDX_IRQ_CLR  = 4'h7;
  localparam logic [15:0] LOWER_RESET  = 16'h0800;
  localparam logic [15:0] UPPER_RESET  = 16'h07FF;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0]  SOFT_RESET   = 8'h3C;
  localparam logic [3:0]  LOW_NIBBLE   = 4'h0;
  localparam logic [3:0]  HIGH_NIBBLE  = 4'hF;
  // status bit positions
  localparam int BIT_A_UNDER = 0;
  localparam int BIT_A_OVER  = 1;
  localparam int BIT_B_UNDER = 4;
  localparam int BIT_B_OVER  = 5;
  // irq event bits: one per conversion channel
  localparam logic [1:0]  IRQ_RESET = 2'h0;

  // one conversion result with its completion strobe
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } dclm_conv_t;

  // widened compare pair
  typedef struct packed {
    logic [15:0] lower;
    logic [15:0] upper;
  } dclm_limits_t;
endpackage

// ### rtl/dclm_compare.sv
// per channel limit comparator
`timescale 1ns/100ps
module dclm_compare (
  // limits and result
  input  wire dclm_pkg::dclm_limits_t limits,
  input  wire dclm_pkg::dclm_conv_t   conv,
  // indications, valid only with conv.valid
  output logic                        under_hit,
  output logic                        over_hit
);
  // strict compares: equal to a limit is no violation
  assign under_hit = conv.valid && (conv.data < limits.lower);
  assign over_hit  = conv.valid && (conv.data > limits.upper);
endmodule

// ### rtl/dclm_top.sv
// limit monitor register bank with classic wishbone slave
`timescale 1ns/100ps
module dclm_top (
  // clock and reset
  input  wire  logic                 sys_clk,
  input  wire  logic                 rst_n,
  // conversion results
  input  wire  dclm_pkg::dclm_conv_t conv_a,
  input  wire  dclm_pkg::dclm_conv_t conv_b,
  // wishbone slave
  input  wire  logic                 wb_cyc_i,
  input  wire  logic                 wb_stb_i,
  input  wire  logic                 wb_we_i,
  input  wire  logic [31:0]          wb_adr_i,
  input  wire  logic [3:0]           wb_sel_i,
  input  wire  logic [31:0]          wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // interrupt
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_meta_n;
  logic rst_sync_n;

  // async assert, two-flop release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        req;
  logic        wr_lo;
  logic        wr_hi;
  logic [3:0]  idx;
  logic        mapped;
  logic        rd_status;
  logic        wr_access;

  // one access per request, ack drops the cycle after
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx       = wb_adr_i[5:2];
  assign wr_access = req && wb_we_i;
  assign wr_lo     = wr_access && wb_sel_i[0];
  assign wr_hi     = wr_access && wb_sel_i[1];
  assign rd_status = req && !wb_we_i && (idx == dclm_pkg::IDX_STATUS);
  assign mapped    = (wb_adr_i[31:6] == 26'h0000000) && (wb_adr_i[1:0] == 2'h0) &&
                     (idx >= dclm_pkg::IDX_CONFIG2) && (idx <= dclm_pkg::IDX_IRQ_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // limit registers, low 12 bits writable
  logic [11:0] lower_field;
  logic [11:0] upper_field;

  // the index nibble is not stored, it is rebuilt on read
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lower_field <= dclm_pkg::LOWER_RESET[11:0];
      upper_field <= dclm_pkg::UPPER_RESET[11:0];
    end else begin
      if (idx == dclm_pkg::IDX_LOWER) begin
        if (wr_lo) lower_field[7:0]  <= wb_dat_i[7:0];
        if (wr_hi) lower_field[11:8] <= wb_dat_i[11:8];
      end
      if (idx == dclm_pkg::IDX_UPPER) begin
        if (wr_lo) upper_field[7:0]  <= wb_dat_i[7:0];
        if (wr_hi) upper_field[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  // widened compare values
  dclm_pkg::dclm_limits_t limits;
  assign limits.lower = {lower_field, dclm_pkg::LOW_NIBBLE};
  assign limits.upper = {upper_field, dclm_pkg::HIGH_NIBBLE};

  ////////////////////////////////////////////////////////////////////////////
  // comparators, one per channel
  logic [1:0]        under_hit;
  logic [1:0]        over_hit;
  dclm_pkg::dclm_conv_t conv [2];
  assign conv[0] = conv_a;
  assign conv[1] = conv_b;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // each channel judged on its own strobe
      dclm_compare u_cmp (
        .limits    (limits),
        .conv      (conv[ch]),
        .under_hit (under_hit[ch]),
        .over_hit  (over_hit[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // soft reset through the config reset field
  logic soft_clear;
  assign soft_clear = wr_lo && (idx == dclm_pkg::IDX_CONFIG2) &&
                      (wb_dat_i[7:0] == dclm_pkg::SOFT_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // sticky limit flags; a new hit wins over a read clear
  logic flag_a_under;
  logic flag_a_over;
  logic flag_b_under;
  logic flag_b_over;
  logic clr_flags;
  assign clr_flags = rd_status || soft_clear;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_a_under <= 1'b0;
      flag_a_over  <= 1'b0;
      flag_b_under <= 1'b0;
      flag_b_over  <= 1'b0;
    end else begin
      flag_a_under <= under_hit[0] || (flag_a_under && !clr_flags);
      flag_a_over  <= over_hit[0]  || (flag_a_over  && !clr_flags);
      flag_b_under <= under_hit[1] || (flag_b_under && !clr_flags);
      flag_b_over  <= over_hit[1]  || (flag_b_over  && !clr_flags);
    end
  end

  logic [15:0] status_word;
  always_comb begin
    status_word = dclm_pkg::STATUS_RESET;
    status_word[15:12]                 = dclm_pkg::IDX_STATUS;
    status_word[dclm_pkg::BIT_A_UNDER] = flag_a_under;
    status_word[dclm_pkg::BIT_A_OVER]  = flag_a_over;
    status_word[dclm_pkg::BIT_B_UNDER] = flag_b_under;
    status_word[dclm_pkg::BIT_B_OVER]  = flag_b_over;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: one sticky event bit per channel on any violation
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] irq_event;
  logic [1:0] irq_clr;
  assign irq_event = under_hit | over_hit;
  assign irq_clr   = (wr_lo && (idx == dclm_pkg::IDX_IRQ_CLR)) ? wb_dat_i[1:0] : 2'h0;

  // set beats clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status <= dclm_pkg::IRQ_RESET;
    end else begin
      irq_status <= irq_event | (irq_status & ~irq_clr);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= dclm_pkg::IRQ_RESET;
    end else if (wr_lo && (idx == dclm_pkg::IDX_IRQ_EN)) begin
      irq_enable <= wb_dat_i[1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // read mux and ack, one wait-free cycle
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    case (idx)
      dclm_pkg::IDX_CONFIG2: next_rdata = {dclm_pkg::IDX_CONFIG2, 12'h000};
      dclm_pkg::IDX_STATUS:  next_rdata = status_word;
      dclm_pkg::IDX_LOWER:   next_rdata = {dclm_pkg::IDX_LOWER, lower_field};
      dclm_pkg::IDX_UPPER:   next_rdata = {dclm_pkg::IDX_UPPER, upper_field};
      dclm_pkg::IDX_IRQ_EN:  next_rdata = {14'h0000, irq_enable};
      dclm_pkg::IDX_IRQ_CLR: next_rdata = {14'h0000, irq_status};
      default:               next_rdata = 16'h0000;
    endcase
    if (!mapped) next_rdata = 16'h0000;
  end

  // unmapped addresses still ack and read zero; writes decode only wb_adr_i[5:2], so aliases still write
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) wb_dat_o <= {16'h0000, next_rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    flag_a_under && !clr_flags |=> flag_a_under)
    else $error("channel a under flag dropped without clear");
  read_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    rd_status && !under_hit[1] |=> !flag_b_under)
    else $error("status read did not clear channel b under flag");
  b_over_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_b.valid && conv_b.data > {upper_field, 4'hF} |=> flag_b_over && status_word[5])
    else $error("channel b over flag not set");
  b_under_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_b.valid && conv_b.data < {lower_field, 4'h0} |=> status_word[4])
    else $error("channel b under flag not set");
  a_over_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_a.valid && conv_a.data > {upper_field, 4'hF} |=> status_word[1])
    else $error("channel a over flag not set");
  a_under_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_a.valid && conv_a.data < {lower_field, 4'h0} |=> status_word[0])
    else $error("channel a under flag not set");
  no_false_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !flag_a_over && !(conv_a.valid && conv_a.data > {upper_field, 4'hF}) |=> !flag_a_over)
    else $error("channel a over flag set without violation");
  soft_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    soft_clear && !conv_a.valid && !conv_b.valid |=> status_word[5:0] == 6'h00 && $stable(lower_field))
    else $error("soft reset did not clear status or changed limits");
  rd_index_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    req && !wb_we_i && idx == dclm_pkg::IDX_LOWER && mapped |=> wb_ack_o && wb_dat_o[15:12] == 4'h4)
    else $error("lower limit read lacks its index");
  ack_one_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // boundary checks: a result equal to a widened limit is never a hit

  // channel a on the lower limit itself
  a_under_equal_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_a.valid && conv_a.data == limits.lower |-> !under_hit[0])
    else $error("channel a under hit on equal value");

  // channel a on the upper limit itself
  a_over_equal_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_a.valid && conv_a.data == limits.upper |-> !over_hit[0])
    else $error("channel a over hit on equal value");

  // channel b on the lower limit itself
  b_under_equal_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_b.valid && conv_b.data == limits.lower |-> !under_hit[1])
    else $error("channel b under hit on equal value");

  // channel b on the upper limit itself
  b_over_equal_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    conv_b.valid && conv_b.data == limits.upper |-> !over_hit[1])
    else $error("channel b over hit on equal value");

  ////////////////////////////////////////////////////////////////////////////
  // no flag rises without its own channel violating

  // channel b under needs a channel b result below the limit
  b_under_none_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !flag_b_under && !(conv_b.valid && conv_b.data < limits.lower) |=> !flag_b_under)
    else $error("channel b under flag set without violation");

  // channel a under needs a channel a result below the limit
  a_under_none_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !flag_a_under && !(conv_a.valid && conv_a.data < limits.lower) |=> !flag_a_under)
    else $error("channel a under flag set without violation");

  // channel b over needs a channel b result above the limit
  b_over_none_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !flag_b_over && !(conv_b.valid && conv_b.data > limits.upper) |=> !flag_b_over)
    else $error("channel b over flag set without violation");

  ////////////////////////////////////////////////////////////////////////////
  // stickiness of the remaining flags and read clear of channel a under

  // channel a over stays up until a clear
  a_over_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    flag_a_over && !clr_flags |=> flag_a_over)
    else $error("channel a over flag dropped without clear");

  // channel b under stays up until a clear
  b_under_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    flag_b_under && !clr_flags |=> flag_b_under)
    else $error("channel b under flag dropped without clear");

  // channel b over stays up until a clear
  b_over_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    flag_b_over && !clr_flags |=> flag_b_over)
    else $error("channel b over flag dropped without clear");

  // a status read drops channel a under unless a new hit lands
  a_read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    rd_status && !under_hit[0] |=> !flag_a_under)
    else $error("status read did not clear channel a under flag");

  ////////////////////////////////////////////////////////////////////////////
  // register bus behaviour

  // status read carries its own index in the top nibble
  status_index_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    req && !wb_we_i && idx == dclm_pkg::IDX_STATUS && mapped |=> wb_dat_o[15:12] == dclm_pkg::IDX_STATUS)
    else $error("status read lacks its index");

  // upper limit read carries its own index in the top nibble
  upper_index_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    req && !wb_we_i && idx == dclm_pkg::IDX_UPPER && mapped |=> wb_dat_o[15:12] == dclm_pkg::IDX_UPPER)
    else $error("upper limit read lacks its index");

  // lower field moves only on a write to its own index
  lower_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !(wr_access && idx == dclm_pkg::IDX_LOWER) |=> $stable(lower_field))
    else $error("lower limit changed without a write");

  // upper field moves only on a write to its own index
  upper_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !(wr_access && idx == dclm_pkg::IDX_UPPER) |=> $stable(upper_field))
    else $error("upper limit changed without a write");

  // every taken request is answered on the next cycle
  ack_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    req |=> wb_ack_o)
    else $error("request not acknowledged");

  // unmapped reads return zero so software sees no ghost register
  unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    req && !wb_we_i && !mapped |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");

  // reserved status bits always read zero
  spare_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    status_word[11:6] == 6'h00 && status_word[3:2] == 2'h0)
    else $error("reserved status bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt behaviour

  // an enabled channel b event raises the line next cycle
  irq_set_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    irq_enable[1] && irq_event[1] && !(wr_lo && idx == dclm_pkg::IDX_IRQ_EN) |=> irq)
    else $error("enabled event did not raise irq");

  // with every enable off the line stays quiet
  irq_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    irq_enable == dclm_pkg::IRQ_RESET |-> !irq)
    else $error("irq raised while masked");

  lim_write_c: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) wr_lo && idx == dclm_pkg::IDX_LOWER);

  b_over_c: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) over_hit[1] ##1 rd_status);
  a_under_c: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) under_hit[0] && irq_enable[0]);
  soft_c: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) soft_clear && flag_a_over);
  irq_c: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) irq ##1 !irq);
endmodule

// ### testbench/dclm_conv_src.sv
// conversion source model standing in for the converter core
`timescale 1ns/100ps
module dclm_conv_src (
  // clock
  input  wire logic           sys_clk,
  // results
  output dclm_pkg::dclm_conv_t conv_a,
  output dclm_pkg::dclm_conv_t conv_b
);
  initial begin
    conv_a = '0;
    conv_b = '0;
  end
  // one valid cycle per result; data inverted after it so stale values never look fresh
  task automatic send(input logic va, input logic [15:0] da, input logic vb, input logic [15:0] db);
    @(posedge sys_clk);
    conv_a <= '{va, da};
    conv_b <= '{vb, db};
    @(posedge sys_clk);
    conv_a <= '{1'b0, ~da};
    conv_b <= '{1'b0, ~db};
  endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the limit monitor register bank
`timescale 1ns/100ps
module tb_top;
  logic                 sys_clk = 1'b0;
  logic                 rst_n;
  dclm_pkg::dclm_conv_t conv_a;
  dclm_pkg::dclm_conv_t conv_b;
  logic                 wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [31:0]          wb_adr_i, wb_dat_i, wb_dat_o;
  logic [15:0]          exp_q[$];
  logic [15:0]          r;
  int                   n_mismatch = 0;
  int                   check_count = 0;

  always #5 sys_clk = ~sys_clk;

  dclm_conv_src u_src (.sys_clk(sys_clk), .conv_a(conv_a), .conv_b(conv_b));
  dclm_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .conv_a(conv_a), .conv_b(conv_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // classic cycle; ack is registered, so its level at the falling edge is what the next rise samples
  task automatic wb(input logic [7:0] adr, input logic we, input logic [15:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= {16'h0, d};
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    @(posedge sys_clk);
    if (n >= 50)
      chk("wb_ack_o", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [15:0] exp);
    exp_q.push_back(exp);
    wb(adr, 1'b0, 16'h0);
  endtask

  // read data monitor, oldest note first
  always @(negedge sys_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0)
        chk("unexpected read", 0, 1);
      else
        chk("wb_dat_o", {16'h0, exp_q.pop_front()}, wb_dat_o);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    void'($urandom(68));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h0C, 16'h3000);
    rd(8'h10, 16'h4800);
    rd(8'h14, 16'h57FF);
    rd(8'h40, 16'h0000);
    r = 16'h8000 | 16'($urandom);
    u_src.send(1'b1, r, 1'b1, ~r);
    rd(8'h0C, 16'h3012);
    rd(8'h0C, 16'h3000);
    wb(8'h10, 1'b1, 16'h4123);
    wb(8'h14, 1'b1, 16'h5456);
    rd(8'h10, 16'h4123);
    rd(8'h14, 16'h5456);
    u_src.send(1'b1, 16'h1230, 1'b1, 16'h456F);
    rd(8'h0C, 16'h3000);
    u_src.send(1'b1, 16'h122F, 1'b0, 16'h0000);
    rd(8'h0C, 16'h3001);
    u_src.send(1'b0, 16'h0000, 1'b1, 16'h4570);
    rd(8'h0C, 16'h3020);
    u_src.send(1'b0, 16'h0000, 1'b1, 16'h0000);
    wb(8'h08, 1'b1, 16'h003C);
    rd(8'h0C, 16'h3000);
    rd(8'h10, 16'h4123);
    // interrupt raised, cleared, masked and unmasked; old events cleared first so the rise is real
    wb(8'h1C, 1'b1, 16'h0003);
    wb(8'h18, 1'b1, 16'h0001);
    @(negedge sys_clk);
    chk("irq", 0, irq);
    u_src.send(1'b1, 16'hFFFF, 1'b0, 16'h0000);
    @(negedge sys_clk);
    chk("irq", 1, irq);
    wb(8'h1C, 1'b1, 16'h0003);
    @(negedge sys_clk);
    chk("irq", 0, irq);
    wb(8'h18, 1'b1, 16'h0002);
    u_src.send(1'b1, 16'hFFFF, 1'b0, 16'h0000);
    @(negedge sys_clk);
    chk("irq", 0, irq);
    wb(8'h18, 1'b1, 16'h0003);
    @(negedge sys_clk);
    chk("irq", 1, irq);
    rd(8'h0C, 16'h3002);
    chk("exp_q size", 0, exp_q.size());
    test_done();
  end
endmodule
